// ===== hw/dummy_never.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== hw/line_state_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module line_state_monitor #(
  parameter int SUSP_CYCLES = usb_gc_pkg::SUSPEND_CYCLES,
  parameter int WAKE_CYCLES = usb_gc_pkg::WAKE_CYCLES
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic ce,
  // bus pins
  input  wire logic dp_pin,
  input  wire logic dm_pin,
  // line events
  usb_line_if.mon   lnk
);
  import usb_gc_pkg::*;

  logic                 dp_s1, dp_s2; // dp synchroniser
  logic                 dm_s1, dm_s2; // dm synchroniser
  logic [SE0_CNT_W-1:0] se0_cnt;      // se0 length
  logic [TIMER_W-1:0]   idle_cnt;     // j length, saturating
  logic                 se0;
  logic                 j_state;

  // pins are asynchronous to clk_sys
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {dp_s1, dp_s2, dm_s1, dm_s2} <= 4'hc; // j idle, so no false se0 or activity after reset
    end else if (ce) begin
      dp_s1 <= dp_pin;
      dp_s2 <= dp_s1;
      dm_s1 <= dm_pin;
      dm_s2 <= dm_s1;
    end
  end

  assign se0     = ~dp_s2 & ~dm_s2;
  assign j_state = dp_s2 & ~dm_s2; // full-speed idle

  // bus reset: se0 held for 32 bit times; end pulse on release
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      se0_cnt       <= '0;
      lnk.bus_reset <= 1'b0;
      lnk.reset_end <= 1'b0;
    end else if (ce) begin
      if (!se0) begin
        se0_cnt       <= '0;
        lnk.bus_reset <= 1'b0;
        lnk.reset_end <= lnk.bus_reset;
      end else begin
        lnk.reset_end <= 1'b0;
        if (se0_cnt != SE0_CNT_W'(SE0_CYCLES)) begin
          se0_cnt <= se0_cnt + 1'b1;
        end else begin
          lnk.bus_reset <= 1'b1;
        end
      end
    end
  end

  // idle timer; saturates so the suspend pulse fires once per idle stretch
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      idle_cnt        <= '0;
      lnk.suspend_hit <= 1'b0;
      lnk.idle_5ms    <= 1'b0;
      lnk.nonidle     <= 1'b0;
    end else if (ce) begin
      lnk.nonidle     <= ~j_state;
      lnk.suspend_hit <= j_state && (idle_cnt == TIMER_W'(SUSP_CYCLES - 1));
      lnk.idle_5ms    <= j_state && (idle_cnt >= TIMER_W'(WAKE_CYCLES - 1));
      if (!j_state) begin
        idle_cnt <= '0;
      end else if (idle_cnt != TIMER_W'(WAKE_CYCLES)) begin
        idle_cnt <= idle_cnt + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ===== hw/usb_device_global_control.sv
`timescale 1ns/100ps
`default_nettype none
//Contract
//- enable bit runs controller; clear resets, gates
//- suspend clock bit stops 48 MHz clock
//- remote wake sent only enabled, clocked, 5ms
//- detach floats pull-up pin, else driven high
//- resume flag set on request, cleared after
//- configured flag cleared by hardware or bus reset
//- address enable clear means answer address 0
//- bus activity in suspend sets wake flag
//- end of bus reset sets sticky flag
//- three millisecond idle sets suspend flag
//- data port pushes and pops selected FIFO
//- selected endpoint byte count in two registers
//- address enable answers zero, then stored address
module usb_device_global_control #(
  parameter int SUSPEND_CYCLES = usb_gc_pkg::SUSPEND_CYCLES,
  parameter int WAKE_CYCLES    = usb_gc_pkg::WAKE_CYCLES,
  parameter int RESUME_CYCLES  = usb_gc_pkg::RESUME_CYCLES
) (
  // clock, reset, enable
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  input  wire logic                        ce,
  // special-function register port
  input  wire logic [7:0]                  sfr_addr,
  input  wire logic                        sfr_wr,
  input  wire logic                        sfr_rd,
  input  wire logic [7:0]                  sfr_wdata,
  output logic      [7:0]                  sfr_rdata,
  // bus line pins
  input  wire logic                        dp_pin,
  input  wire logic                        dm_pin,
  output logic                             vref_o,
  output logic                             vref_oe_n,
  output logic                             resume_k,
  // controller core events and interrupt enables
  input  wire logic                        sof_token,
  input  wire logic                        wakeup_irq_enable,
  input  wire logic                        end_of_reset_irq_enable,
  input  wire logic                        sof_irq_enable,
  input  wire logic                        suspend_irq_enable,
  output logic                             usb_irq,
  // endpoint FIFO port
  input  wire logic [7:0]                  fifo_rdata,
  input  wire logic [usb_gc_pkg::NUM_EP-1:0][usb_gc_pkg::COUNT_W-1:0] rx_count,
  output logic                             fifo_push,
  output logic                             fifo_pop,
  output logic      [7:0]                  fifo_byte,
  output logic      [usb_gc_pkg::EP_SEL_W-1:0] fifo_ep,
  // controller control
  output logic                             ctrl_rst,
  output logic                             xcvr_en,
  output logic                             clk48_en,
  output logic      [6:0]                  answer_addr,
  output logic                             function_enabled
);
  import usb_gc_pkg::*;
  usb_line_if lnk ();
  logic                controller_enable, suspend_clock_gate, send_remote_wakeup;
  logic                detach, remote_wakeup_enable, configured_flag, address_enable_flag;
  logic                upstream_resume_active;          // hardware owned
  logic                wakeup_flag, end_of_reset_flag;  // sticky events
  logic                start_of_frame_flag, suspend_flag;
  logic                suspended, wake_req;             // bus in suspend, fresh request
  logic [7:0]          function_address_register;       // enable + address
  logic [EP_SEL_W-1:0] selected_endpoint;
  logic [TIMER_W-1:0]  drive_cnt;
  resume_state_t       rs_state;
  logic [7:0]          ctl_view, int_view;
  logic [COUNT_W-1:0]  sel_count;
  // one decode for every write strobe and the FIFO pop; read data uses its own case
  function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] off);
    hit = strobe && (a == off);
  endfunction
  line_state_monitor #(
    .SUSP_CYCLES (SUSPEND_CYCLES),
    .WAKE_CYCLES (WAKE_CYCLES)
  ) u_mon (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .ce      (ce),
    .dp_pin  (dp_pin),
    .dm_pin  (dm_pin),
    .lnk     (lnk)
  );
  // request only on a fresh 0->1 write, so a bit left set does not retrigger
  assign wake_req = hit(sfr_wr, sfr_addr, ADDR_GLOBAL_CONTROL) && sfr_wdata[CTL_SEND_WAKE]
                    && !send_remote_wakeup && remote_wakeup_enable;
  assign sel_count = rx_count[selected_endpoint];
  // firmware-owned control bits
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {controller_enable, suspend_clock_gate, send_remote_wakeup, detach} <= CTL_RESET[7:4];
      remote_wakeup_enable <= CTL_RESET[CTL_WAKE_EN];
    end else if (ce && hit(sfr_wr, sfr_addr, ADDR_GLOBAL_CONTROL)) begin
      controller_enable    <= sfr_wdata[CTL_ENABLE];
      suspend_clock_gate   <= sfr_wdata[CTL_SUSP_CLK];
      send_remote_wakeup   <= sfr_wdata[CTL_SEND_WAKE];
      detach               <= sfr_wdata[CTL_DETACH];
      remote_wakeup_enable <= sfr_wdata[CTL_WAKE_EN];
    end
  end
  // configured and address enable: hardware clear beats firmware write
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      configured_flag     <= CTL_RESET[CTL_CONFIGURED];
      address_enable_flag <= CTL_RESET[CTL_ADDR_EN];
    end else if (ce) begin
      if (lnk.bus_reset || !controller_enable) begin
        configured_flag     <= 1'b0;
        address_enable_flag <= 1'b0;
      end else if (hit(sfr_wr, sfr_addr, ADDR_GLOBAL_CONTROL)) begin
        configured_flag     <= sfr_wdata[CTL_CONFIGURED];
        address_enable_flag <= sfr_wdata[CTL_ADDR_EN];
      end
    end
  end
  // address and endpoint select registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      function_address_register <= FADDR_RESET;
      selected_endpoint         <= EPSEL_RESET;
    end else if (ce) begin
      if (hit(sfr_wr, sfr_addr, ADDR_FUNC_ADDRESS)) begin
        function_address_register <= sfr_wdata;
      end
      if (hit(sfr_wr, sfr_addr, ADDR_EP_SELECT)) begin
        selected_endpoint <= sfr_wdata[EP_SEL_W-1:0];
      end
    end
  end
  // upstream resume sequencer; waits until clocks run and bus idle 5 ms
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rs_state               <= RS_IDLE;
      upstream_resume_active <= 1'b0;
      resume_k               <= 1'b0;
      drive_cnt              <= '0;
    end else if (ce) begin
      if (!controller_enable) begin
        rs_state               <= RS_IDLE;
        upstream_resume_active <= 1'b0;
        resume_k               <= 1'b0;
      end else begin
        case (rs_state)
          RS_IDLE: begin
            if (wake_req) begin
              upstream_resume_active <= 1'b1;
              rs_state               <= RS_WAIT;
            end
          end
          RS_WAIT: begin
            if (!suspend_clock_gate && lnk.idle_5ms) begin
              resume_k  <= 1'b1;
              drive_cnt <= '0;
              rs_state  <= RS_DRIVE;
            end
          end
          RS_DRIVE: begin
            drive_cnt <= drive_cnt + 1'b1;
            if (drive_cnt == TIMER_W'(RESUME_CYCLES - 1)) begin
              resume_k               <= 1'b0;
              upstream_resume_active <= 1'b0;
              rs_state               <= RS_IDLE;
            end
          end
          default: begin
            rs_state <= RS_IDLE;
          end
        endcase
      end
    end
  end
  // suspend state of the bus, left on any activity
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      suspended <= 1'b0;
    end else if (ce) begin
      if (lnk.suspend_hit) begin
        suspended <= 1'b1;
      end else if (lnk.nonidle) begin
        suspended <= 1'b0;
      end
    end
  end
  // sticky event flags: a zero write clears, a set in the same cycle wins
  always_ff @(posedge clk_sys) begin
    if (sys_rst || (ce && !controller_enable)) begin
      {wakeup_flag, end_of_reset_flag, start_of_frame_flag, suspend_flag} <= 4'h0;
    end else if (ce) begin
      if (hit(sfr_wr, sfr_addr, ADDR_INT_FLAGS)) begin
        wakeup_flag         <= wakeup_flag & sfr_wdata[INT_WAKEUP];
        end_of_reset_flag   <= end_of_reset_flag & sfr_wdata[INT_EOR];
        start_of_frame_flag <= start_of_frame_flag & sfr_wdata[INT_SOF];
        suspend_flag        <= suspend_flag & sfr_wdata[INT_SUSPEND];
      end
      // own resume drive is not bus activity from the host
      if (suspended && lnk.nonidle && !resume_k) begin
        wakeup_flag <= 1'b1;
      end
      if (lnk.reset_end) begin
        end_of_reset_flag <= 1'b1;
      end
      if (sof_token) begin
        start_of_frame_flag <= 1'b1;
      end
      if (lnk.suspend_hit) begin
        suspend_flag <= 1'b1;
      end
    end
  end
  assign ctl_view = {controller_enable, suspend_clock_gate, send_remote_wakeup, detach,
                     upstream_resume_active, remote_wakeup_enable, configured_flag,
                     address_enable_flag};
  assign int_view = {2'b00, wakeup_flag, end_of_reset_flag, start_of_frame_flag, 2'b00,
                     suspend_flag};
  // registered read data; unmapped addresses read zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
    end else if (ce && sfr_rd) begin
      case (sfr_addr)
        ADDR_GLOBAL_CONTROL: sfr_rdata <= ctl_view;
        ADDR_INT_FLAGS:      sfr_rdata <= int_view;
        ADDR_FUNC_ADDRESS:   sfr_rdata <= function_address_register;
        ADDR_EP_SELECT:      sfr_rdata <= {5'h00, selected_endpoint};
        ADDR_FIFO_DATA:      sfr_rdata <= fifo_rdata;
        ADDR_COUNT_LOW:      sfr_rdata <= sel_count[7:0];
        ADDR_COUNT_HIGH:     sfr_rdata <= {5'h00, sel_count[COUNT_W-1:8]};
        default:             sfr_rdata <= 8'h00;
      endcase
    end
  end
  // FIFO strobes toward the selected endpoint
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fifo_push <= 1'b0;
      fifo_pop  <= 1'b0;
      fifo_byte <= 8'h00;
      fifo_ep   <= EPSEL_RESET;
    end else if (ce) begin
      fifo_push <= hit(sfr_wr, sfr_addr, ADDR_FIFO_DATA);
      fifo_pop  <= hit(sfr_rd, sfr_addr, ADDR_FIFO_DATA);
      fifo_byte <= sfr_wdata;
      fifo_ep   <= selected_endpoint;
    end
  end
  // controller control outputs; resume detection lives in the monitor, not gated
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_rst         <= 1'b1;
      xcvr_en          <= 1'b0;
      clk48_en         <= 1'b0;
      vref_o           <= 1'b1;
      vref_oe_n        <= 1'b0;
      answer_addr      <= 7'h00;
      function_enabled <= 1'b0;
      usb_irq          <= 1'b0;
    end else if (ce) begin
      ctrl_rst         <= !controller_enable;
      xcvr_en          <= controller_enable;
      clk48_en         <= controller_enable && !suspend_clock_gate;
      vref_o           <= 1'b1;
      vref_oe_n        <= detach;
      answer_addr      <= address_enable_flag ? function_address_register[6:0] : 7'h00;
      function_enabled <= function_address_register[FA_ENABLE];
      usb_irq          <= (wakeup_flag && wakeup_irq_enable) ||
                          (end_of_reset_flag && end_of_reset_irq_enable) ||
                          (start_of_frame_flag && sof_irq_enable) ||
                          (suspend_flag && suspend_irq_enable);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_enable_gates_all: assert property ((ce && !controller_enable) |=> ctrl_rst && !xcvr_en && !clk48_en) else $error("disabled controller not gated");
  a_suspend_clock_off: assert property ((ce && suspend_clock_gate) |=> !clk48_en) else $error("clock runs in suspend");
  a_resume_conditions: assert property ($rose(resume_k) |-> $past(lnk.idle_5ms) && !$past(suspend_clock_gate) && upstream_resume_active) else $error("resume sent without conditions");
  a_detach_floats: assert property ((ce && detach) |=> vref_oe_n) else $error("pull-up pin driven during detach");
  a_resume_flag_set: assert property ((ce && rs_state == RS_IDLE && controller_enable && wake_req) |=> upstream_resume_active) else $error("resume flag not set");
  a_bus_reset_clears: assert property ((ce && lnk.bus_reset) |=> !configured_flag && !address_enable_flag) else $error("bus reset kept flags");
  a_default_address: assert property ((ce && !address_enable_flag) |=> answer_addr == 7'h00) else $error("nonzero address while disabled");
  a_sof_set_wins: assert property ((ce && controller_enable && sof_token) |=> start_of_frame_flag) else $error("frame event lost");
  a_eor_sticky: assert property ((ce && controller_enable && lnk.reset_end) |=> end_of_reset_flag) else $error("end of reset lost");
  a_int_reserved_zero: assert property ((ce && hit(sfr_rd, sfr_addr, ADDR_INT_FLAGS)) |=> sfr_rdata[7:6] == 2'b00 && sfr_rdata[2:1] == 2'b00) else $error("reserved bits nonzero");
  a_fifo_push_pulse: assert property ((ce && hit(sfr_wr, sfr_addr, ADDR_FIFO_DATA)) |=> fifo_push && fifo_byte == $past(sfr_wdata)) else $error("port write not pushed");
  c_resume_drive: cover property ($rose(resume_k));
  c_wake_flag: cover property ($rose(wakeup_flag));
  c_bus_reset_end: cover property ($rose(end_of_reset_flag));
  c_suspend: cover property ($rose(suspend_flag) ##1 usb_irq);
endmodule
`default_nettype wire

// ===== hw/usb_gc_pkg.sv
package usb_gc_pkg;

  // register addresses in special-function space
  localparam logic [7:0] ADDR_GLOBAL_CONTROL = 8'hbc;
  localparam logic [7:0] ADDR_INT_FLAGS      = 8'hbd;
  localparam logic [7:0] ADDR_FUNC_ADDRESS   = 8'hc6;
  localparam logic [7:0] ADDR_EP_SELECT      = 8'hc7;
  localparam logic [7:0] ADDR_FIFO_DATA      = 8'hcf;
  localparam logic [7:0] ADDR_COUNT_LOW      = 8'he2;
  localparam logic [7:0] ADDR_COUNT_HIGH     = 8'he3;

  // global control bit positions
  localparam int CTL_ENABLE     = 7;
  localparam int CTL_SUSP_CLK   = 6;
  localparam int CTL_SEND_WAKE  = 5;
  localparam int CTL_DETACH     = 4;
  localparam int CTL_UP_RESUME  = 3;
  localparam int CTL_WAKE_EN    = 2;
  localparam int CTL_CONFIGURED = 1;
  localparam int CTL_ADDR_EN    = 0;

  // interrupt flag bit positions
  localparam int INT_WAKEUP  = 5;
  localparam int INT_EOR     = 4;
  localparam int INT_SOF     = 3;
  localparam int INT_SUSPEND = 0;

  // function address register
  localparam int FA_ENABLE = 7;

  // reset values
  localparam logic [7:0] CTL_RESET   = 8'h00;
  localparam logic [7:0] FADDR_RESET = 8'h80;
  localparam logic [2:0] EPSEL_RESET = 3'h0;

  // sizes
  localparam int NUM_EP    = 8;
  localparam int EP_SEL_W  = 3;
  localparam int COUNT_W   = 11;
  localparam int TIMER_W   = 20;
  localparam int SE0_CNT_W = 9;

  // timing
  localparam int CLK_PERIOD_PS   = 10000;
  localparam int FS_BIT_PS       = 83333;
  localparam int RESET_SE0_BITS  = 32;
  localparam int SE0_CYCLES      = (RESET_SE0_BITS * FS_BIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYCLES_PER_MS   = 1000000000 / CLK_PERIOD_PS;
  localparam int SUSPEND_MS      = 3;
  localparam int REMOTE_WAKE_MS  = 5;
  localparam int RESUME_DRIVE_MS = 10;
  localparam int SUSPEND_CYCLES  = SUSPEND_MS * CYCLES_PER_MS;
  localparam int WAKE_CYCLES     = REMOTE_WAKE_MS * CYCLES_PER_MS;
  localparam int RESUME_CYCLES   = RESUME_DRIVE_MS * CYCLES_PER_MS;

  typedef enum logic [1:0] {RS_IDLE, RS_WAIT, RS_DRIVE} resume_state_t;

endpackage

// ===== hw/usb_line_if.sv
`timescale 1ns/100ps
`default_nettype none
interface usb_line_if;
  logic bus_reset;   // se0 held past reset length
  logic reset_end;   // pulse when such se0 ends
  logic suspend_hit; // pulse when idle reaches suspend length
  logic nonidle;     // line is not in j
  logic idle_5ms;    // line idle long enough for remote wake
  modport mon (output bus_reset, reset_end, suspend_hit, nonidle, idle_5ms);
  modport ctl (input bus_reset, reset_end, suspend_hit, nonidle, idle_5ms);
endinterface
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
// bench: register rows first, then line events and remote wake
module tb;
  import usb_gc_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic w; logic [7:0] e;} row_t;
  logic                             clk_sys = 1'b0;
  logic                             sys_rst = 1'b1;
  logic [7:0]                       sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [7:0]                       fifo_rdata = 8'h6e, fifo_byte;
  logic                             sfr_wr = 1'b0, sfr_rd = 1'b0, sof_token = 1'b0, running = 1'b1;
  logic                             wk_en = 1'b1, sof_en = 1'b1, eor_en = 1'b0, sp_en = 1'b0;
  logic                             ce = 1'b1; // dropped once to check the freeze
  logic [NUM_EP-1:0][COUNT_W-1:0]   rx_count = {NUM_EP{11'h000}};
  logic                             vref_o, vref_oe_n, resume_k, usb_irq, fifo_push, fifo_pop;
  logic                             ctrl_rst, xcvr_en, clk48_en, function_enabled;
  logic [2:0]                       fifo_ep;
  logic [6:0]                       answer_addr;
  wire logic                        dp_pin, dm_pin;
  int                               n_errors = 0, total_checks = 0, cycles = 0, hi;
  // plain rows: optional write, then read back; configured needs enable already set
  row_t rows [10] = '{'{8'hbc, 8'h9f, 1'b1, 8'h94}, '{8'hbc, 8'h9f, 1'b1, 8'h97},
    '{8'hbd, 8'hff, 1'b1, 8'h00},
    '{8'hc6, 8'h85, 1'b1, 8'h85}, '{8'he2, 8'hff, 1'b1, 8'ha3}, '{8'he3, 8'hff, 1'b1, 8'h05},
    '{8'hc7, 8'h03, 1'b1, 8'h03}, '{8'he2, 8'h00, 1'b0, 8'hf1}, '{8'he3, 8'h00, 1'b0, 8'h02},
    '{8'h00, 8'h55, 1'b1, 8'h00}};
  // short counts keep the run brief
  usb_device_global_control #(.SUSPEND_CYCLES(50), .WAKE_CYCLES(80), .RESUME_CYCLES(20)) u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .dp_pin(dp_pin),
    .dm_pin(dm_pin), .vref_o(vref_o), .vref_oe_n(vref_oe_n), .resume_k(resume_k),
    .sof_token(sof_token), .wakeup_irq_enable(wk_en), .end_of_reset_irq_enable(eor_en),
    .sof_irq_enable(sof_en), .suspend_irq_enable(sp_en), .usb_irq(usb_irq),
    .fifo_rdata(fifo_rdata), .rx_count(rx_count), .fifo_push(fifo_push), .fifo_pop(fifo_pop),
    .fifo_byte(fifo_byte), .fifo_ep(fifo_ep), .ctrl_rst(ctrl_rst), .xcvr_en(xcvr_en),
    .clk48_en(clk48_en), .answer_addr(answer_addr), .function_enabled(function_enabled));
  usb_host_model u_host (.clk_sys(clk_sys), .running(running), .resume_k(resume_k),
    .dp_pin(dp_pin), .dm_pin(dm_pin));
  // clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask
  // one-cycle read, data is registered
  task automatic rdck(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    check("sfr_rdata", sfr_rdata, e);
  endtask
  // control outputs lag a write by two cycles
  task automatic pins(input logic [7:0] e);
    @(negedge clk_sys);
    check("pins", {3'h0, ctrl_rst, xcvr_en, clk48_en, vref_o, vref_oe_n}, e);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    rx_count[0] = 11'h5a3;
    rx_count[3] = 11'h2f1;
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    rdck(8'hbc, 8'h00);
    rdck(8'hc6, 8'h80);
    pins(8'h12);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rdck(rows[i].a, rows[i].e);
    end
    pins(8'h0f);
    check("answer_addr", {1'b0, answer_addr}, 8'h05);
    check("function_enabled", {7'h00, function_enabled}, 8'h01);
    wr(8'hbc, 8'hc7);
    pins(8'h0a);
    wr(8'hbc, 8'h87);
    pins(8'h0e);
    // a write while the clock enable is low must not land
    ce = 1'b0;
    wr(8'hbc, 8'hc7);
    pins(8'h0e);
    ce = 1'b1;
    rdck(8'hbc, 8'h87);
    wr(8'hcf, 8'h3c);
    check("push", {fifo_push, 4'h0, fifo_ep}, 8'h83);
    check("fifo_byte", fifo_byte, 8'h3c);
    rdck(8'hcf, 8'h6e);
    check("pop", {7'h00, fifo_pop}, 8'h01);
    @(negedge clk_sys);
    check("pulses", {6'h00, fifo_push, fifo_pop}, 8'h00);
    // start of frame, then a clear that meets a new set
    sof_token = 1'b1;
    @(negedge clk_sys);
    sof_token = 1'b0;
    rdck(8'hbd, 8'h08);
    check("usb_irq", {7'h00, usb_irq}, 8'h01);
    @(negedge clk_sys);
    sfr_addr = 8'hbd;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b1;
    sof_token = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
    sof_token = 1'b0;
    rdck(8'hbd, 8'h08);
    wr(8'hbd, 8'h00);
    rdck(8'hbd, 8'h00);
    // bus reset, then the line is left idle
    running = 1'b0;
    u_host.send_se0(300);
    rdck(8'hbc, 8'h84);
    check("answer_addr", {1'b0, answer_addr}, 8'h00);
    rdck(8'hbd, 8'h10);
    eor_en = 1'b1;
    @(negedge clk_sys);
    check("usb_irq", {7'h00, usb_irq}, 8'h01);
    eor_en = 1'b0;
    repeat (25) @(negedge clk_sys);
    rdck(8'hbd, 8'h10);
    repeat (30) @(negedge clk_sys);
    rdck(8'hbd, 8'h11);
    check("usb_irq", {7'h00, usb_irq}, 8'h00);
    sp_en = 1'b1;
    @(negedge clk_sys);
    check("usb_irq", {7'h00, usb_irq}, 8'h01);
    sp_en = 1'b0;
    u_host.send_k(3);
    rdck(8'hbd, 8'h31);
    check("usb_irq", {7'h00, usb_irq}, 8'h01);
    wr(8'hbc, 8'h84);
    wr(8'hbd, 8'h00);
    rdck(8'hbd, 8'h00);
    // remote wake with the host's permission
    wr(8'hbc, 8'ha4);
    rdck(8'hbc, 8'hac);
    for (int i = 0; i < 300 && resume_k !== 1'b1; i++) @(negedge clk_sys);
    hi = 0;
    while (resume_k === 1'b1 && hi < 100) begin
      hi++;
      @(negedge clk_sys);
    end
    check("resume_len", hi[7:0], 8'h14);
    rdck(8'hbc, 8'ha4);
    rdck(8'hbd, 8'h01);
    // request without the enable is dropped
    wr(8'hbc, 8'h80);
    wr(8'hbc, 8'ha0);
    rdck(8'hbc, 8'ha0);
    repeat (100) @(negedge clk_sys);
    check("resume_k", {7'h00, resume_k}, 8'h00);
    wr(8'hbc, 8'h00);
    pins(8'h12);
    rdck(8'hbd, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ===== sim/usb_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// full-speed host at the pins: j idle, se0 reset, k activity
module usb_host_model (
  // clock
  input  wire logic clk_sys,
  // bench control and device resume drive
  input  wire logic running,
  input  wire logic resume_k,
  // bus lines
  output logic      dp_pin,
  output logic      dm_pin
);
  int         se0_left  = 0;     // se0 cycles still to drive
  int         k_left    = 0;     // k cycles still to drive
  logic [4:0] tick      = 5'h00; // packet spacing, shorter than the suspend idle count
  logic [1:0] host_line = 2'b10; // {dp, dm}, j at rest
  // the host listens while the device drives its resume k
  assign dp_pin = resume_k ? 1'b0 : host_line[1];
  assign dm_pin = resume_k ? 1'b1 : host_line[0];
  // line driver, moves just after the falling edge
  always @(negedge clk_sys) begin
    tick = tick + 5'h01;
    if (se0_left > 0) begin
      host_line = 2'b00;
      se0_left  = se0_left - 1;
    end else if (k_left > 0 || (running && tick < 5'h02)) begin
      host_line = 2'b01;
      k_left    = (k_left > 0) ? k_left - 1 : 0;
    end else begin
      host_line = 2'b10;
    end
  end
  // bus reset of n se0 cycles; the bench's 300 is just over 32 bit times
  task automatic send_se0(input int n);
    @(posedge clk_sys);
    se0_left = n;
    repeat (n + 2) @(negedge clk_sys);
  endtask
  // short burst of bus activity
  task automatic send_k(input int n);
    @(posedge clk_sys);
    k_left = n;
    repeat (n + 2) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire
